// ===== cmd_defs.svh
// Constants for the capture mode configuration decode block.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef CMD_DEFS_SVH
`define CMD_DEFS_SVH

`define CMD_CLK_PERIOD_NS     100
`define CMD_FINE_STEP_NS      16000
`define CMD_COARSE_STEP_NS    4096000
`define CMD_FINE_STEP_CYC     (`CMD_FINE_STEP_NS / `CMD_CLK_PERIOD_NS)
`define CMD_COARSE_STEP_CYC   (`CMD_COARSE_STEP_NS / `CMD_CLK_PERIOD_NS)
`define CMD_PRESET_CENTRE     8'h02
`define CMD_PRESET_NEIGHBOUR  8'h05
`define CMD_ROWS              8'h80
`define CMD_VALID_ROWS_VERT   8'h7e
`define CMD_RATIO_STEP_TENTHS 8'h7d
`define CMD_OFFSET_STEP_MV    8'h08
`define CMD_FINE_RESET        8'h01
`define CMD_COARSE_RESET      8'h00

`endif

// ===== cmd_pkg.sv
// Types shared by the capture mode configuration decode block.
// Assumes nothing of its surroundings.
package cmd_pkg;
	typedef enum logic [1:0] {
		CMD_EDGE_NONE  = 2'b00,
		CMD_EDGE_HORIZ = 2'b01,
		CMD_EDGE_VERT  = 2'b10,
		CMD_EDGE_TWOD  = 2'b11
	} cmd_edge_e;
	typedef enum logic [1:0] {
		CMD_PROJ_NONE  = 2'b00,
		CMD_PROJ_HORIZ = 2'b01,
		CMD_PROJ_VERT  = 2'b10
	} cmd_proj_e;
	typedef enum logic [1:0] {
		CMD_EXP_IDLE = 2'b00,
		CMD_EXP_RUN  = 2'b01,
		CMD_EXP_READ = 2'b10
	} cmd_exp_e;
endpackage

// ===== cmd_capture_decode.sv
// Capture mode configuration decode: exposure timer, edge filter,
// projection select and offset. Registers are loaded by strobes from the
// serial loader outside; the host keeps the mode constraints it owns.
// Notes on behaviour
// - Exposure lasts fine count times 16 us plus coarse count times 4.096 ms.
// - Both counts zero: read without pixel reset; clamp correction unavailable.
// - Preset bit forces centre 02, neighbour 05; writes to them ignored.
// - Preset plus direction: 000 none, 001 horiz, 110 vert, 111 2D.
// - Enhancement top bit high selects pure edge; host keeps low for images.
// - Low three enhancement bits give ratio 0 to 87.5% in 12.5% steps.
// - Edge is ratio times centre differences; enhancement adds centre pixel.
// - Edge modes output 128x128; vertical and 2D have 126 valid rows.
// - Projection bits: none, horizontal alone, vertical alone decode as listed.
// - Horizontal projection fires all rows; vertical swaps scanner roles.
// - Offset top bit is sign, high positive; low bits sixteen 8 mV steps.
`include "cmd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module cmd_capture_decode
	import cmd_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Register load strobes and data
	input  wire logic              fineWr,
	input  wire logic              coarseWr,
	input  wire logic              modeWr,
	input  wire logic              centreWr,
	input  wire logic              neighbourWr,
	input  wire logic              projWr,
	input  wire logic [7:0]        wrData,
	// Capture control
	input  wire logic              captureStart,
	input  wire logic              autoBlackCalibration,
	// Pixel neighbourhood in
	input  wire logic [7:0]        pixCentre,
	input  wire logic [7:0]        pixNorth,
	input  wire logic [7:0]        pixSouth,
	input  wire logic [7:0]        pixWest,
	input  wire logic [7:0]        pixEast,
	// Exposure status
	output var  logic              exposing,
	output var  logic              exposeDone,
	output var  logic              pixelResetEn,
	output var  logic              clampAvail,
	// Filter configuration out
	output var  logic [1:0]        edgeMode,
	output var  logic              edgeOnlySelect,
	output var  logic [7:0]        centreCoef,
	output var  logic [7:0]        neighbourCoef,
	output var  logic [7:0]        validRows,
	output var  logic signed [11:0] edgePixel,
	// Projection out
	output var  logic [1:0]        projMode,
	output var  logic              rowsAllActive,
	output var  logic              colsAllActive,
	output var  logic signed [8:0] projOffsetMv,
	output var  logic              projCalibWarn
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0] exposureFineCount_ff;
	logic [7:0] exposureCoarseCount_ff;
	logic       vertEnhancePreset_ff;
	logic [1:0] edgeDirectionSelect_ff;
	logic [3:0] enhanceCtrl_ff;
	logic [7:0] centreCoef_ff;
	logic [7:0] neighbourCoef_ff;
	logic       horizProjSelect_ff;
	logic       vertProjSelect_ff;
	logic [4:0] projOutputOffset_ff;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			exposureFineCount_ff   <= `CMD_FINE_RESET;
			exposureCoarseCount_ff <= `CMD_COARSE_RESET;
		end else begin
			if (fineWr) begin
				exposureFineCount_ff <= wrData;
			end
			if (coarseWr) begin
				exposureCoarseCount_ff <= wrData;
			end
		end
	end

	// Mode byte: bit 7 preset, bits 6:5 direction, bits 3:0 enhancement.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vertEnhancePreset_ff   <= 1'b0;
			edgeDirectionSelect_ff <= 2'b00;
			enhanceCtrl_ff         <= 4'h0;
		end else if (modeWr) begin
			vertEnhancePreset_ff   <= wrData[7];
			edgeDirectionSelect_ff <= wrData[6:5];
			enhanceCtrl_ff         <= wrData[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			centreCoef_ff    <= 8'h01;
			neighbourCoef_ff <= 8'h00;
		end else if (vertEnhancePreset_ff || (modeWr && wrData[7])) begin
			centreCoef_ff    <= `CMD_PRESET_CENTRE;
			neighbourCoef_ff <= `CMD_PRESET_NEIGHBOUR;
		end else begin
			if (centreWr) begin
				centreCoef_ff <= wrData;
			end
			if (neighbourWr) begin
				neighbourCoef_ff <= wrData;
			end
		end
	end

	// Projection byte: bit 7 horizontal, bit 6 vertical, bits 4:0 offset.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			horizProjSelect_ff  <= 1'b0;
			vertProjSelect_ff   <= 1'b0;
			projOutputOffset_ff <= 5'h00;
		end else if (projWr) begin
			horizProjSelect_ff  <= wrData[7];
			vertProjSelect_ff   <= wrData[6];
			projOutputOffset_ff <= wrData[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Exposure timer. Both counts share one 16-bit step timer, so no count of
	// cycles ever exceeds one coarse step.
	cmd_exp_e    expState_ff;
	logic [15:0] stepCnt_ff;
	logic [7:0]  fineLeft_ff;
	logic [7:0]  coarseLeft_ff;
	logic        readOnly;

	assign readOnly = (exposureFineCount_ff == 8'h00) && (exposureCoarseCount_ff == 8'h00);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			expState_ff   <= CMD_EXP_IDLE;
			stepCnt_ff    <= 16'h0000;
			fineLeft_ff   <= 8'h00;
			coarseLeft_ff <= 8'h00;
			exposing      <= 1'b0;
			exposeDone    <= 1'b0;
		end else begin
			exposeDone <= 1'b0;
			unique case (expState_ff)
				CMD_EXP_IDLE: begin
					if (captureStart) begin
						fineLeft_ff   <= exposureFineCount_ff;
						coarseLeft_ff <= exposureCoarseCount_ff;
						stepCnt_ff    <= 16'h0000;
						expState_ff   <= readOnly ? CMD_EXP_READ : CMD_EXP_RUN;
						exposing      <= !readOnly;
					end
				end
				CMD_EXP_RUN: begin
					if (coarseLeft_ff != 8'h00) begin
						if (stepCnt_ff == 16'(`CMD_COARSE_STEP_CYC - 1)) begin
							stepCnt_ff    <= 16'h0000;
							coarseLeft_ff <= coarseLeft_ff - 8'h01;
						end else begin
							stepCnt_ff <= stepCnt_ff + 16'h0001;
						end
					end else if (fineLeft_ff != 8'h00) begin
						if (stepCnt_ff == 16'(`CMD_FINE_STEP_CYC - 1)) begin
							stepCnt_ff  <= 16'h0000;
							fineLeft_ff <= fineLeft_ff - 8'h01;
						end else begin
							stepCnt_ff <= stepCnt_ff + 16'h0001;
						end
					end else begin
						exposing    <= 1'b0;
						expState_ff <= CMD_EXP_READ;
					end
				end
				CMD_EXP_READ: begin
					exposeDone  <= 1'b1;
					expState_ff <= CMD_EXP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pixelResetEn <= 1'b1;
			clampAvail   <= 1'b1;
		end else begin
			pixelResetEn <= !readOnly;
			clampAvail   <= !readOnly;
		end
	end

	////////////////////////////////////////////////////////////////////////
	cmd_edge_e edgeDec;

	always_comb begin
		unique case ({vertEnhancePreset_ff, edgeDirectionSelect_ff})
			3'b001:  edgeDec = CMD_EDGE_HORIZ;
			3'b110:  edgeDec = CMD_EDGE_VERT;
			3'b111:  edgeDec = CMD_EDGE_TWOD;
			default: edgeDec = CMD_EDGE_NONE;
		endcase
	end

	logic signed [10:0] diffSum;
	logic signed [14:0] scaled;
	logic signed [11:0] nxt_edgePixel;

	always_comb begin
		unique case (edgeDec)
			CMD_EDGE_VERT:  diffSum = 11'sd2 * $signed({3'b000, pixCentre})
				- $signed({3'b000, pixNorth}) - $signed({3'b000, pixSouth});
			CMD_EDGE_HORIZ: diffSum = 11'sd2 * $signed({3'b000, pixCentre})
				- $signed({3'b000, pixWest}) - $signed({3'b000, pixEast});
			CMD_EDGE_TWOD:  diffSum = 11'sd4 * $signed({3'b000, pixCentre})
				- $signed({3'b000, pixNorth}) - $signed({3'b000, pixSouth})
				- $signed({3'b000, pixWest}) - $signed({3'b000, pixEast});
			CMD_EDGE_NONE:  diffSum = 11'sd0;
		endcase
	end

	assign scaled = 15'(diffSum * $signed({1'b0, enhanceCtrl_ff[2:0]}));

	always_comb begin
		if (edgeDec == CMD_EDGE_NONE) begin
			nxt_edgePixel = $signed({4'h0, pixCentre});
		end else if (enhanceCtrl_ff[3]) begin
			nxt_edgePixel = 12'(scaled >>> 3);
		end else begin
			nxt_edgePixel = 12'(scaled >>> 3) + $signed({4'h0, pixCentre});
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			edgeMode       <= CMD_EDGE_NONE;
			edgeOnlySelect <= 1'b0;
			centreCoef     <= 8'h01;
			neighbourCoef  <= 8'h00;
			validRows      <= `CMD_ROWS;
			edgePixel      <= 12'sd0;
		end else begin
			edgeMode       <= edgeDec;
			edgeOnlySelect <= enhanceCtrl_ff[3];
			centreCoef     <= centreCoef_ff;
			neighbourCoef  <= neighbourCoef_ff;
			edgePixel      <= nxt_edgePixel;
			validRows <= (edgeDec == CMD_EDGE_VERT || edgeDec == CMD_EDGE_TWOD) ?
				`CMD_VALID_ROWS_VERT : `CMD_ROWS;
		end
	end

	////////////////////////////////////////////////////////////////////////
	cmd_proj_e projDec;

	always_comb begin
		unique case ({vertProjSelect_ff, horizProjSelect_ff})
			2'b01:   projDec = CMD_PROJ_HORIZ;
			2'b10:   projDec = CMD_PROJ_VERT;
			default: projDec = CMD_PROJ_NONE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			projMode      <= CMD_PROJ_NONE;
			rowsAllActive <= 1'b0;
			colsAllActive <= 1'b0;
			projOffsetMv  <= 9'sd0;
			projCalibWarn <= 1'b0;
		end else begin
			projMode <= projDec;
			rowsAllActive <= (projDec == CMD_PROJ_HORIZ);
			colsAllActive <= (projDec == CMD_PROJ_VERT);
			projOffsetMv <= projOutputOffset_ff[4] ?
				$signed({1'b0, 8'(projOutputOffset_ff[3:0] * `CMD_OFFSET_STEP_MV)}) :
				-$signed({1'b0, 8'(projOutputOffset_ff[3:0] * `CMD_OFFSET_STEP_MV)});
			projCalibWarn <= (projDec != CMD_PROJ_NONE) && !autoBlackCalibration;
		end
	end

endmodule

`default_nettype wire

// ===== cmd_capture_decode_properties.sv
// Port-level checks for the capture mode configuration decode block.
// Assumes one clock, clk, and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cmd_capture_decode_properties
	import cmd_pkg::*;
(
	// Inputs
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              modeWr,
	input wire logic              centreWr,
	input wire logic              projWr,
	input wire logic [7:0]        wrData,
	input wire logic              captureStart,
	// Outputs
	input wire logic              exposing,
	input wire logic              exposeDone,
	input wire logic              pixelResetEn,
	input wire logic [1:0]        edgeMode,
	input wire logic [7:0]        centreCoef,
	input wire logic [7:0]        neighbourCoef,
	input wire logic [7:0]        validRows,
	input wire logic [1:0]        projMode,
	input wire logic              rowsAllActive,
	input wire logic              colsAllActive,
	input wire logic signed [8:0] projOffsetMv
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic presetTrk;
	always_ff @(posedge clk) begin
		if (sys_rst)
			presetTrk <= 1'b0;
		else if (modeWr)
			presetTrk <= wrData[7];
	end
	function automatic logic [1:0] mdec(input logic [7:0] b);
		case (b[7:5])
			3'b001: return 2'd1;
			3'b110: return 2'd2;
			3'b111: return 2'd3;
			default: return 2'd0;
		endcase
	endfunction
	function automatic logic [1:0] pdec(input logic [1:0] b);
		return (b == 2'b10) ? 2'd1 : (b == 2'b01) ? 2'd2 : 2'd0;
	endfunction
	AST_EDGE_DECODE: assert property (modeWr |-> ##2
		edgeMode == mdec($past(wrData, 2))) else $error("edge mode decode wrong");
	AST_VALID_ROWS: assert property (modeWr |-> ##2 validRows ==
		((mdec($past(wrData, 2)) >= 2'd2) ? 8'h7e : 8'h80)) else $error("valid rows wrong");
	AST_PRESET: assert property (modeWr && wrData[7] |-> ##2
		centreCoef == 8'h02 && neighbourCoef == 8'h05) else $error("preset not applied");
	AST_COEF_LOCK: assert property (presetTrk && centreWr && !modeWr |->
		##2 centreCoef == 8'h02) else $error("coefficient write not blocked");
	AST_PROJ: assert property (projWr |-> ##2
		projMode == pdec($past(wrData[7:6], 2))) else $error("projection decode wrong");
	AST_SCAN: assert property (projWr |-> ##2
		rowsAllActive == ($past(wrData[7:6], 2) == 2'b10) &&
		colsAllActive == ($past(wrData[7:6], 2) == 2'b01))
		else $error("scanner roles wrong");
	AST_OFFSET: assert property (projWr |-> ##2 projOffsetMv ==
		($past(wrData[4], 2) ? 9'sd8 : -9'sd8) * $signed({1'b0, $past(wrData[3:0], 2)}))
		else $error("projection offset wrong");
	AST_READ_ONLY: assert property (captureStart && !exposing && !pixelResetEn
		|-> ##2 exposeDone) else $error("read-only done late");
	AST_DONE_PULSE: assert property (exposeDone |=> !exposeDone) else
		$error("done longer than one cycle");
endmodule
`default_nettype wire

// ===== cmd_host.sv
// Host controller model: loads registers by strobe and starts captures.
// Assumes the decode block samples its inputs on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module cmd_host (
	// Clock
	input  wire logic        clk,
	// Register loading
	output var  logic [5:0]  wrStb,
	output var  logic [7:0]  wrData,
	// Capture control and pixels
	output var  logic        captureStart,
	output var  logic        autoBlackCalibration,
	output var  logic [39:0] pixBus
);
	initial begin
		wrStb = 6'h00;
		wrData = 8'h00;
		captureStart = 1'b0;
		autoBlackCalibration = 1'b1;
		pixBus = {8'd100, 8'd60, 8'd80, 8'd95, 8'd50};
	end
	// Released data is inverted so a stale byte is never mistaken for a load.
	task automatic wr(input int sel, input logic [7:0] d);
		@(posedge clk);
		wrStb <= 6'h01 << sel;
		wrData <= d;
		@(posedge clk);
		wrStb <= 6'h00;
		wrData <= ~d;
	endtask
	task automatic start();
		@(posedge clk);
		captureStart <= 1'b1;
		@(posedge clk);
		captureStart <= 1'b0;
	endtask
	task automatic calib(input logic v);
		@(posedge clk);
		autoBlackCalibration <= v;
	endtask
endmodule
`default_nettype wire

// ===== capture_mode_config_decode_tb.sv
// Self-checking bench for the capture mode configuration decode block.
// Assumes the host model drives every design input except clock and reset.
`timescale 1ns/1ps
`default_nettype none
module capture_mode_config_decode_tb;
	import cmd_pkg::*;
	logic clk, sysRst, captureStart, autoBlackCalibration;
	logic [5:0] wrStb;
	logic [7:0] wrData, m, centreCoef, neighbourCoef, validRows;
	logic [39:0] pixBus;
	logic exposing, exposeDone, pixelResetEn, clampAvail, edgeOnlySelect;
	logic rowsAllActive, colsAllActive, projCalibWarn;
	logic [1:0] edgeMode, projMode;
	logic signed [11:0] edgePixel;
	logic signed [8:0] projOffsetMv;
	int numErrors = 0, checked = 0, cycles = 0, em, d, n, base, hi;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial sysRst = 1'b1;
	cmd_host i_cmd_host (.clk(clk), .wrStb(wrStb), .wrData(wrData),
		.captureStart(captureStart), .autoBlackCalibration(autoBlackCalibration),
		.pixBus(pixBus));
	cmd_capture_decode i_cmd_capture_decode (.clk(clk), .sys_rst(sysRst),
		.fineWr(wrStb[0]), .coarseWr(wrStb[1]), .modeWr(wrStb[2]),
		.centreWr(wrStb[3]), .neighbourWr(wrStb[4]), .projWr(wrStb[5]),
		.wrData(wrData), .captureStart(captureStart),
		.autoBlackCalibration(autoBlackCalibration), .pixCentre(pixBus[39:32]),
		.pixNorth(pixBus[31:24]), .pixSouth(pixBus[23:16]), .pixWest(pixBus[15:8]),
		.pixEast(pixBus[7:0]), .exposing(exposing), .exposeDone(exposeDone),
		.pixelResetEn(pixelResetEn), .clampAvail(clampAvail), .edgeMode(edgeMode),
		.edgeOnlySelect(edgeOnlySelect), .centreCoef(centreCoef),
		.neighbourCoef(neighbourCoef), .validRows(validRows), .edgePixel(edgePixel),
		.projMode(projMode), .rowsAllActive(rowsAllActive),
		.colsAllActive(colsAllActive), .projOffsetMv(projOffsetMv),
		.projCalibWarn(projCalibWarn));
	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		checked++;
		if (g !== e) begin
			numErrors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cfg(input int sel, input logic [7:0] v);
		i_cmd_host.wr(sel, v);
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic finishTest();
		$display("Counts: %0d checks, %0d mismatches", checked, numErrors);
		if (numErrors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// The whole run needs about 42000 cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			numErrors++;
			finishTest();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		#1;
		chk("centreCoef", 12'h001, centreCoef);
		chk("validRows", 12'h080, validRows);
		chk("pixelResetEn", 12'h001, pixelResetEn);
		$display("reset test done");
		for (int i = 0; i < 16; i++) begin
			em = (i[2:0] == 3'd1) ? 1 : (i[2:0] == 3'd6) ? 2 : (i[2:0] == 3'd7) ? 3 : 0;
			d = (em == 1) ? 55 : (em == 2) ? 60 : (em == 3) ? 115 : 0;
			m = {i[2], i[1:0], 1'b0, i[3] && (em != 0), i[2:0]};
			cfg(2, m);
			chk("edgeMode", 12'(em), edgeMode);
			chk("validRows", (em >= 2) ? 12'h07e : 12'h080, validRows);
			chk("edgeOnlySelect", 12'(m[3]), edgeOnlySelect);
			d = ((d * i[2:0]) >>> 3) + (m[3] ? 0 : 100);
			chk("edgePixel", 12'(d), edgePixel);
		end
		$display("edge mode test done");
		// Clear the preset left by the sweep so the forcing below is really seen.
		cfg(2, 8'h00);
		cfg(3, 8'h33);
		cfg(4, 8'h44);
		chk("centreCoef", 12'h033, centreCoef);
		chk("neighbourCoef", 12'h044, neighbourCoef);
		cfg(2, 8'h80);
		chk("centreCoef", 12'h002, centreCoef);
		chk("neighbourCoef", 12'h005, neighbourCoef);
		cfg(3, 8'h33);
		cfg(4, 8'h44);
		chk("centreCoef", 12'h002, centreCoef);
		chk("neighbourCoef", 12'h005, neighbourCoef);
		$display("preset test done");
		for (int i = 0; i < 4; i++) begin
			i_cmd_host.calib(i != 1);
			cfg(5, {i[1], i[0], 1'b0, i[0], ~i[3:0]});
			em = (i == 2) ? 1 : (i == 1) ? 2 : 0;
			chk("projMode", 12'(em), projMode);
			chk("rowsAllActive", 12'(em == 1), rowsAllActive);
			chk("colsAllActive", 12'(em == 2), colsAllActive);
			chk("projOffsetMv", 12'((i[0] ? 8 : -8) * (15 - i)), projOffsetMv);
			chk("projCalibWarn", 12'(i == 1), projCalibWarn);
		end
		$display("projection test done");
		// Exposure stays legal because no edge mode is selected here.
		for (int k = 0; k < 3; k++) begin
			cfg(0, (k > 0) ? 8'h01 : 8'h00);
			cfg(1, (k == 2) ? 8'h01 : 8'h00);
			base = (k == 2) ? 41120 : (k == 1) ? 160 : 0;
			chk("pixelResetEn", 12'(k > 0), pixelResetEn);
			chk("clampAvail", 12'(k > 0), clampAvail);
			i_cmd_host.start();
			n = 0;
			hi = 0;
			while (exposeDone !== 1'b1 && n < 50000) begin
				@(posedge clk);
				#1;
				n++;
				if (exposing === 1'b1)
					hi++;
			end
			// Done comes one edge to leave the count and one more to pulse.
			chk("exposeTime", 12'h001, 12'((k == 0) ? (n == 1) : (n == base + 2)));
			chk("exposing", 12'h001, 12'(hi == base));
		end
		$display("exposure test done");
		finishTest();
	end
endmodule
bind cmd_capture_decode cmd_capture_decode_properties i_props (.clk(clk),
	.sys_rst(sys_rst), .modeWr(modeWr), .centreWr(centreWr), .projWr(projWr),
	.wrData(wrData), .captureStart(captureStart), .exposing(exposing),
	.exposeDone(exposeDone), .pixelResetEn(pixelResetEn), .edgeMode(edgeMode),
	.centreCoef(centreCoef), .neighbourCoef(neighbourCoef), .validRows(validRows),
	.projMode(projMode), .rowsAllActive(rowsAllActive),
	.colsAllActive(colsAllActive), .projOffsetMv(projOffsetMv));
`default_nettype wire
